// *** design/tcf_pkg.sv ***
// Package: constants and types for the four-mode 8-bit timer counter
package tcf_pkg;
    localparam int CNT_W = 8;
    localparam logic [7:0] CNT_ZERO = 8'h00;
    localparam logic [7:0] CNT_ONE = 8'h01;
    localparam logic [7:0] CNT_MAX = 8'hff;
    localparam logic [7:0] COMPARE_RESET = 8'hff;
    localparam logic [2:0] CLK_SRC_EXT = 3'h7;
    localparam logic [1:0] MODE_TIMER = 2'h0;
    localparam logic [1:0] MODE_RSVD = 2'h1;
    localparam logic [1:0] MODE_DIV = 2'h2;
    localparam logic [1:0] MODE_PWM = 2'h3;

    typedef enum logic [1:0] {
        TCF_HS_RUN,
        TCF_HS_IDLE,
        TCF_LS_RUN,
        TCF_LS_SLEEP
    } tcf_opmode_type;

    typedef struct packed {
        logic run_control;
        logic [2:0] clock_source_select;
        logic [1:0] mode_select;
    } tcf_ctrl_type;

    typedef struct packed {
        logic divider_out_pin;
        logic pwm_out_pin_n;
        logic timer_match_irq;
    } tcf_out_type;
endpackage : tcf_pkg

// *** design/tcf_timer.sv ***
// Four-mode 8-bit timer counter: timer, event counter, divider and PWM
// Summary of operation
// - Four modes: interval timer, event counter, divider output, PWM output.
// - Mode 00 timer or event, 01 reserved, 10 divider, 11 PWM.
// - Timer: count internal ticks, on match interrupt, clear, restart from zero.
// - Event mode counts every rising edge of the event pin.
// - Event mode checks match on falling edge of the event pin.
// - No event counting in low-speed modes.
// - Divider gives 50% square wave, half period equals compare value.
// - Divider match inverts pin, interrupts, clears counter, keeps counting.
// - Stopped counter forces divider pin high.
// - PWM with 8-bit duty resolution from internal clock.
// - PWM: counter equal buffered duty drives pin low, no clear.
// - PWM: overflow drives pin high and raises interrupt.
// - Stopped counter holds PWM pin high.
// - PWM duty is double buffered, transferred at period end.
// - First duty value loads into shadow when run is set.
// - PWM only in high-speed run and idle modes.
// - Clearing run stops and zeroes counter; setting run starts it.
// - Entering stop mode clears run control automatically.
`timescale 1ns/10ps
`default_nettype none
module tcf_timer #(
    parameter int CNT_W = tcf_pkg::CNT_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_en,
    // Control writes: control register (run, source, mode) write strobe and value, compare write strobe
    input wire logic ctrl_wr,
    input wire tcf_pkg::tcf_ctrl_type ctrl_wdata,
    input wire logic compare_wr,
    input wire logic [CNT_W-1:0] compare_wdata,
    // One pulse per selected internal source clock period
    input wire logic src_tick,
    input wire tcf_pkg::tcf_opmode_type opmode,
    input wire logic stop_mode_entry,
    input wire logic event_input_pin,
    output tcf_pkg::tcf_ctrl_type timer_control,
    output logic [CNT_W-1:0] compare_value,
    output logic [CNT_W-1:0] count_value,
    output tcf_pkg::tcf_out_type pins
);

    // Counter, duty shadow and compare storage
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    logic [CNT_W-1:0] shadow_r;
    logic [CNT_W-1:0] compare_r;
    tcf_pkg::tcf_ctrl_type ctrl_r;
    logic div_r;
    logic pwm_n_r;
    logic irq_r;
    // Event pin synchroniser and edge history
    logic ev_meta_r;
    logic ev_sync_r;
    logic ev_prev_r;
    logic ev_rise;
    logic ev_fall;
    // Counting qualifiers
    logic ext_src;
    logic high_speed;
    logic running;
    logic start_edge;
    logic tick;
    logic match;
    logic overflow;
    logic irq_nxt;

    // Comparator results shared by the match, overflow and PWM logic
    logic [CNT_W-1:0] cnt_inc;
    logic cnt_at_cmp;
    logic cnt_before_cmp;
    logic cnt_at_max;
    logic int_match;
    logic ext_match;
    logic pwm_mode;
    logic div_mode;
    logic duty_hit;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ev_meta_r <= 1'b0;
            ev_sync_r <= 1'b0;
        end else if (clk_en) begin
            ev_meta_r <= event_input_pin;
            ev_sync_r <= ev_meta_r;
        end
    end

    // Edge history resets to the pin's idle low level, so reset makes no false edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ev_prev_r <= 1'b0;
        end else if (clk_en) begin
            ev_prev_r <= ev_sync_r;
        end
    end

    // Edges are single-clock pulses of the synchronised pin
    assign ev_rise = ev_sync_r & ~ev_prev_r;
    assign ev_fall = ~ev_sync_r & ev_prev_r;
    assign ext_src = (ctrl_r.clock_source_select == tcf_pkg::CLK_SRC_EXT);
    assign high_speed = (opmode == tcf_pkg::TCF_HS_RUN)
                        || (opmode == tcf_pkg::TCF_HS_IDLE);
    // Only a 0 to 1 write of run counts as a start
    assign start_edge = ctrl_wr & ctrl_wdata.run_control & ~ctrl_r.run_control;

    // Control register; stop entry wins over a simultaneous write
    // Stop entry only drops run; mode and source survive for the restart
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= '0;
        end else if (clk_en) begin
            if (stop_mode_entry) begin
                ctrl_r.run_control <= 1'b0;
            end else if (ctrl_wr) begin
                ctrl_r <= ctrl_wdata;
            end
        end
    end

    // A zero compare is outside the legal range and gives a 256-tick period
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            compare_r <= tcf_pkg::COMPARE_RESET;
        end else if (clk_en && compare_wr) begin
            compare_r <= compare_wdata;
        end
    end

    // Modes the current speed cannot supply stay frozen, pins high
    always_comb begin
        running = ctrl_r.run_control;
        case (ctrl_r.mode_select)
            tcf_pkg::MODE_TIMER: begin
                running = running & (~ext_src | high_speed);
            end
            tcf_pkg::MODE_DIV: begin
                running = running & ~ext_src;
            end
            tcf_pkg::MODE_PWM: begin
                running = running & high_speed & ~ext_src;
            end
            // Reserved code keeps the counter parked
            tcf_pkg::MODE_RSVD: begin
                running = 1'b0;
            end
            default: begin
                running = 1'b0;
            end
        endcase
    end

    // Shared comparators; the increment is cut back to the counter width
    assign cnt_inc = CNT_W'(count_r + tcf_pkg::CNT_ONE);
    assign cnt_at_cmp = (count_r == compare_r);
    assign cnt_before_cmp = (cnt_inc == compare_r);
    assign cnt_at_max = (count_r == tcf_pkg::CNT_MAX);
    assign pwm_mode = (ctrl_r.mode_select == tcf_pkg::MODE_PWM);
    assign div_mode = (ctrl_r.mode_select == tcf_pkg::MODE_DIV);

    assign tick = running & (ext_src ? ev_rise : src_tick);
    // Internal match clears on the tick that would reach compare
    // so a period or half period is exactly compare ticks long
    assign int_match = src_tick & cnt_before_cmp;
    // Event match sampled on falling edge after compare is reached
    assign ext_match = ev_fall & cnt_at_cmp;
    assign match = running & (ext_src ? ext_match : int_match);
    assign overflow = tick & cnt_at_max;
    // Duty hit when this tick brings the counter onto the shadow
    assign duty_hit = tick & (cnt_inc == shadow_r);

    // Mode dependent counter behaviour
    // A match outranks a plain tick, so the cleared value is never skipped
    always_comb begin
        count_nxt = count_r;
        irq_nxt = 1'b0;
        if (!ctrl_r.run_control) begin
            count_nxt = tcf_pkg::CNT_ZERO;
        end else begin
            case (ctrl_r.mode_select)
                tcf_pkg::MODE_TIMER, tcf_pkg::MODE_DIV: begin
                    if (match) begin
                        count_nxt = tcf_pkg::CNT_ZERO;
                        irq_nxt = 1'b1;
                    end else if (tick) begin
                        count_nxt = cnt_inc;
                    end
                end
                tcf_pkg::MODE_PWM: begin
                    if (tick) begin
                        count_nxt = cnt_inc;
                    end
                    irq_nxt = overflow;
                end
                // Reserved code holds the count
                tcf_pkg::MODE_RSVD: begin
                    count_nxt = count_r;
                end
                default: begin
                    count_nxt = count_r;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_r <= tcf_pkg::CNT_ZERO;
        end else if (clk_en) begin
            count_r <= count_nxt;
        end
    end

    // Interrupt is a one-cycle pulse; nothing has to clear it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_r <= 1'b0;
        end else if (clk_en) begin
            irq_r <= irq_nxt;
        end
    end

    // Software should rewrite compare just after the interrupt, far from reload
    // Shadow loads at period end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shadow_r <= tcf_pkg::COMPARE_RESET;
        end else if (clk_en) begin
            if (start_edge) begin
                shadow_r <= compare_r;
            end else if (overflow && pwm_mode) begin
                // A write in this same cycle is not yet visible; it waits a period
                shadow_r <= compare_r;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_r <= 1'b1;
        end else if (clk_en) begin
            if (!running || !div_mode) begin
                div_r <= 1'b1;
            end else if (match) begin
                // The toggle lands on the same edge as the interrupt pulse
                // Invert on match
                div_r <= ~div_r;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pwm_n_r <= 1'b1;
        end else if (clk_en) begin
            if (!running || !pwm_mode) begin
                pwm_n_r <= 1'b1;
            end else if (overflow) begin
                // Overflow drives high
                // Overflow outranks a duty hit in the same tick
                pwm_n_r <= 1'b1;
            end else if (duty_hit) begin
                pwm_n_r <= 1'b0;
            end
        end
    end

    assign timer_control = ctrl_r;
    assign compare_value = compare_r;
    assign count_value = count_r;
    // Pins and status come straight from flip-flops
    always_comb begin
        pins = '0;
        pins.divider_out_pin = div_r;
        pins.pwm_out_pin_n = pwm_n_r;
        pins.timer_match_irq = irq_r;
    end

endmodule : tcf_timer
`default_nettype wire

// *** verif/tcf_src.sv ***
// Event pulse source standing at the counter's input pin
`timescale 1ns/10ps
`default_nettype none
module tcf_src (
    input wire logic clk,
    output logic event_input_pin
);
    initial event_input_pin = 1'b0;
    task automatic pulse(input int h, input int l);
        @(posedge clk);
        #1 event_input_pin = 1'b1;
        repeat (h < 3 ? 3 : h) @(posedge clk);
        #1 event_input_pin = 1'b0;
        repeat (l < 3 ? 3 : l) @(posedge clk);
    endtask : pulse
endmodule : tcf_src
`default_nettype wire

// *** verif/tcf_chk.sv ***
// Port assertions for the timer counter
`timescale 1ns/10ps
`default_nettype none
module tcf_chk #(
    parameter int CNT_W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic src_tick,
    input wire tcf_pkg::tcf_opmode_type opmode,
    input wire logic stop_mode_entry,
    input wire tcf_pkg::tcf_ctrl_type timer_control,
    input wire logic [CNT_W-1:0] compare_value,
    input wire logic [CNT_W-1:0] count_value,
    input wire tcf_pkg::tcf_out_type pins
);
    logic run;
    logic tk;
    logic ext;
    logic hs;
    logic eq;
    logic [1:0] md;
    assign run = timer_control.run_control;
    assign tk = run && clk_en && src_tick;
    assign ext = timer_control.clock_source_select == tcf_pkg::CLK_SRC_EXT;
    assign hs = opmode == tcf_pkg::TCF_HS_RUN || opmode == tcf_pkg::TCF_HS_IDLE;
    // Internal match fires on the tick that would bring the count onto compare
    assign eq = tk && !ext && count_value + 8'h01 == compare_value;
    assign md = timer_control.mode_select;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    property p_div_stop; !run && !$past(run) |-> pins.divider_out_pin; endproperty
    a_div_stop: assert property (p_div_stop) else $error("divider low when idle");
    property p_pwm_stop; !run && !$past(run) |-> pins.pwm_out_pin_n; endproperty
    a_pwm_stop: assert property (p_pwm_stop) else $error("pwm low when idle");
    property p_cnt_clr; !run && !$past(run) |-> count_value == '0; endproperty
    a_cnt_clr: assert property (p_cnt_clr) else $error("count kept when idle");
    property p_tmr; eq && md == tcf_pkg::MODE_TIMER |=> count_value == '0 && pins.timer_match_irq;
    endproperty
    a_tmr: assert property (p_tmr) else $error("timer match missed");
    property p_div; eq && md == tcf_pkg::MODE_DIV |=> pins.timer_match_irq &&
        pins.divider_out_pin != $past(pins.divider_out_pin) && count_value == '0; endproperty
    a_div: assert property (p_div) else $error("divider match missed");
    property p_ovf; tk && hs && !ext && md == tcf_pkg::MODE_PWM && count_value == '1 |=>
        count_value == '0 && pins.pwm_out_pin_n && pins.timer_match_irq; endproperty
    a_ovf: assert property (p_ovf) else $error("pwm overflow missed");
    property p_inc; tk && hs && !ext && md == tcf_pkg::MODE_PWM && count_value != '1 |=>
        count_value == $past(count_value) + 8'h01; endproperty
    a_inc: assert property (p_inc) else $error("pwm count skipped");
    property p_stp; stop_mode_entry && clk_en |=> !run; endproperty
    a_stp: assert property (p_stp) else $error("run kept in stop");
endmodule : tcf_chk
`default_nettype wire

// *** verif/tcf_timer_tb.sv ***
// Self-checking bench for the four-mode timer counter
`timescale 1ns/10ps
`default_nettype none
module timer_counter_four_mode_8bit_tb;
    logic clk = 1'b0, rst = 1'b1, ctrl_wr = 1'b0, compare_wr = 1'b0;
    logic src_tick = 1'b1, stop_mode_entry = 1'b0, ev;
    logic [7:0] compare_wdata = 8'h00, count_value, c, cmp_q;
    logic [31:0] seed = 32'h0000ca41;
    tcf_pkg::tcf_ctrl_type ctrl_wdata = '0, timer_control;
    tcf_pkg::tcf_opmode_type opmode = tcf_pkg::TCF_HS_RUN;
    tcf_pkg::tcf_out_type pins;
    int n_fail, checks_done, nt, lt, nl, ll, per, lowp, nirq, k;
    tcf_timer dut_u (.clk(clk), .rst(rst), .clk_en(1'b1), .ctrl_wr(ctrl_wr),
        .ctrl_wdata(ctrl_wdata), .compare_wr(compare_wr), .compare_wdata(compare_wdata),
        .src_tick(src_tick), .opmode(opmode), .stop_mode_entry(stop_mode_entry),
        .event_input_pin(ev), .timer_control(timer_control), .compare_value(cmp_q),
        .count_value(count_value), .pins(pins));
    tcf_src src_u (.clk(clk), .event_input_pin(ev));
    always #10 clk = ~clk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic sel, input logic [7:0] v);
        ctrl_wr = sel;
        compare_wr = !sel;
        ctrl_wdata = tcf_pkg::tcf_ctrl_type'(v[5:0]);
        compare_wdata = v;
        @(posedge clk);
        #1 ctrl_wr = 1'b0;
        compare_wr = 1'b0;
        // One idle edge keeps back-to-back writes out of one time step
        @(posedge clk);
        #1;
    endtask : wr
    task automatic wirq();
        k = nirq + 1;
        for (int i = 0; i < 3000 && nirq < k; i++) begin
            @(posedge clk);
            #1;
        end
        if (nirq < k) begin
            n_fail++;
            $display("[ERR] %0t interrupt wait ran out", $time);
        end
    endtask : wirq
    task automatic halt(input logic [7:0] v);
        wr(1'b1, v);
        repeat (2) @(posedge clk);
        #1 chk(count_value, 8'h00);
        chk({pins.divider_out_pin, pins.pwm_out_pin_n}, 2'b11);
    endtask : halt
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : close_out
    // Ticks are counted with the values the design saw at each edge
    always @(posedge clk) begin
        if (pins.timer_match_irq === 1'b1) begin
            per = nt - lt;
            lt = nt;
            lowp = nl - ll;
            ll = nl;
            nirq++;
        end
        nt += int'(src_tick);
        nl += int'(src_tick && pins.pwm_out_pin_n === 1'b0);
        #1 src_tick = rnd() % 4 != 0;
    end
    initial begin
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
        chk({count_value, pins}, 11'h006);
        for (int m = 0; m < 2; m++) begin
            // compare kept in the legal range, above one so toggles stay apart
            wr(1'b0, 8'(rnd() % 31 + 2));
            c = compare_wdata;
            chk(cmp_q, c);
            wr(1'b1, m ? 8'h22 : 8'h20);
            wirq();
            wirq();
            chk(per, c);
            if (m) chk(pins.divider_out_pin, 1'b1);
            halt(m ? 8'h02 : 8'h00);
        end
        $display("timer and divider done");
        wr(1'b0, 8'(rnd() % 200 + 20));
        c = compare_wdata;
        wr(1'b1, 8'h2f);
        // next duty written early in the period, far from the reload
        wr(1'b0, c + 8'h10);
        wirq();
        chk(lowp, 256 - c);
        wirq();
        chk(lowp, 240 - c);
        halt(8'h0f);
        opmode = tcf_pkg::TCF_LS_RUN;
        k = nirq;
        wr(1'b1, 8'h2f);
        repeat (600) @(posedge clk);
        #1 chk({8'(nirq - k), pins.pwm_out_pin_n}, 9'h001);
        halt(8'h0f);
        $display("pwm done");
        wr(1'b1, 8'h3c);
        for (int i = 0; i < 2; i++) src_u.pulse(3, 3);
        #1 chk(count_value, 8'h00);
        halt(8'h1c);
        opmode = tcf_pkg::TCF_HS_RUN;
        wr(1'b0, 8'(rnd() % 5 + 2));
        c = compare_wdata;
        wr(1'b1, 8'h3c);
        for (int i = 1; i < c; i++) src_u.pulse(rnd() % 4 + 3, rnd() % 4 + 3);
        #1 chk(count_value, c - 8'h01);
        k = nirq;
        src_u.pulse(rnd() % 4, 8);
        #1 chk({8'(nirq - k), count_value}, 16'h0100);
        src_u.pulse(3, 5);
        #1 chk(count_value, 8'h01);
        #1 stop_mode_entry = 1'b1;
        @(posedge clk);
        #1 stop_mode_entry = 1'b0;
        chk(timer_control.run_control, 1'b0);
        $display("event and stop done");
        close_out();
    end
    initial begin
        #1000000;
        n_fail++;
        $display("[ERR] %0t watchdog expired", $time);
        close_out();
    end
endmodule : timer_counter_four_mode_8bit_tb
bind tcf_timer tcf_chk #(.CNT_W(CNT_W)) chk_u (.clk(clk), .rst(rst), .clk_en(clk_en),
    .src_tick(src_tick), .opmode(opmode), .stop_mode_entry(stop_mode_entry),
    .timer_control(timer_control), .compare_value(compare_value),
    .count_value(count_value), .pins(pins));
`default_nettype wire
